// ===== design/cio_endpoint.sv
// Endpoint end of the condensed I/O stream port
`timescale 1ns/1ps
// Notes on behaviour
// - All outbound packets share one transmit channel
// - All received packets share one receive channel
// - Beat moves only when valid and ready
// - 64-bit data, one beat per accepted cycle
// - Compact format: user holds transmit keep ones
// - Raw format: user keep ones except last
// - Compact format: receive keep always ones
// - Raw format: receive keep ones except last
// - Keep bit 7 is top byte
// - Last asserted on final beat only
// - Compact user field: source high, destination low
// - User zero-fills upper id byte, short ids
// - Endpoint zero-fills upper id byte, short ids
// - Transmit source id tied to device id
// - Raw format: 8-bit user, bit 1 flag
// - User field meaningful on first beat only
// - One format fixed for both channels
module cio_endpoint #(
   parameter cio_pkg::fmt_e FMT       = cio_pkg::FMT_COMPACT,
   parameter bit            SHORT_IDS = 1'b0
) (
   // Clock, reset and clock-enable shared by both channels
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         ce,
   cio_if.endpoint           port,
   // Packed outbound beat handed to the transport side
   output logic              tx_valid,
   input  wire logic         tx_ready,
   output logic [63:0]       tx_data,
   output logic [7:0]        tx_keep,
   output logic              tx_last,
   output logic [31:0]       tx_user,
   output logic              tx_first,
   // Inbound beat from the transport side
   input  wire logic         rx_valid,
   output logic              rx_ready,
   input  wire logic [63:0]  rx_data,
   input  wire logic [7:0]   rx_keep,
   input  wire logic         rx_last,
   input  wire logic [15:0]  rx_src_id,
   input  wire logic [15:0]  rx_dst_id,
   input  wire logic         rx_crf
);
   // Stage word layout, top down: data, keep, last, user field, first flag
   localparam int BW        = 64 + 8 + 1 + 32 + 1;
   localparam int DATA_MSB  = BW - 1;
   localparam int KEEP_MSB  = BW - 65;
   localparam int LAST_POS  = BW - 73;
   localparam int USER_MSB  = 32;
   localparam int USER_LSB  = 1;
   localparam int FIRST_POS = 0;

   logic          tx_first_r;
   logic          tx_first_nxt;
   logic          rx_first_r;
   logic          rx_first_nxt;
   // Stage words and conditioned fields
   logic [BW-1:0] tx_in_beat;
   logic [BW-1:0] tx_out_beat;
   logic [BW-1:0] rx_in_beat;
   logic [BW-1:0] rx_out_beat;
   logic [31:0]   rx_user_fmt;
   logic [7:0]    rx_keep_fmt;
   logic          rx_out_valid;
   logic          tx_in_ready;
   logic [31:0]   tx_user_in;

   // single transmit channel
   // Every outbound packet type enters through this one stage
   // user field masked off later beats before the stage
   // so the transport side sees it straight from a flop
   assign tx_user_in = tx_first_r ? port.iotx_tuser : cio_pkg::USER_RST;
   assign tx_in_beat = {
      port.iotx_tdata,
      port.iotx_tkeep,
      port.iotx_tlast,
      tx_user_in,
      tx_first_r
   };

   // handshake on transmit
   // Ready is gated by ce inside the stage, so a frozen clock-enable never
   // lets the source believe a beat was taken
   cio_stage #(.W(BW)) u_tx (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .ce        (ce),
      .in_valid  (port.iotx_tvalid),
      .in_ready  (tx_in_ready),
      .in_beat   (tx_in_beat),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_beat  (tx_out_beat)
   );
   // Source sees the stage's own ready
   assign port.iotx_tready = tx_in_ready;

   // first-beat tracking
   // Transmit packet start: set after the last beat, cleared after any other
   always_comb begin
      tx_first_nxt = tx_first_r;
      if (port.iotx_tvalid && tx_in_ready) begin
         tx_first_nxt = port.iotx_tlast;
      end
   end

   // Reset opens a packet, so the very first beat carries the user field
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_first_r <= 1'b1;
      end else if (ce) begin
         tx_first_r <= tx_first_nxt;
      end
   end

   // Receive packet start, tracked the same way on the transport handshake
   always_comb begin
      rx_first_nxt = rx_first_r;
      if (rx_valid && rx_ready) begin
         rx_first_nxt = rx_last;
      end
   end

   // Reset opens a receive packet as well
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rx_first_r <= 1'b1;
      end else if (ce) begin
         rx_first_r <= rx_first_nxt;
      end
   end

   // Transmit outputs straight from the stage flops
   // unpack transmit beat
   assign tx_data  = tx_out_beat[DATA_MSB -: 64];
   assign tx_keep  = tx_out_beat[KEEP_MSB -: 8];
   assign tx_last  = tx_out_beat[LAST_POS];
   assign tx_first = tx_out_beat[FIRST_POS];
   // user already cleared on later beats
   assign tx_user  = tx_out_beat[USER_MSB:USER_LSB];

   // one format for both
   // Receive side formatting follows the same FMT parameter
   always_comb begin
      // Defaults: reserved user bits zero, keep full
      rx_user_fmt = cio_pkg::USER_RST;
      rx_keep_fmt = cio_pkg::KEEP_ALL;
      if (FMT == cio_pkg::FMT_COMPACT) begin
         // upper id byte zeroed when SHORT_IDS is set
         // Narrowing here once keeps the padding the same on every beat
         rx_user_fmt = {cio_pkg::narrow_id(rx_src_id, SHORT_IDS), cio_pkg::narrow_id(rx_dst_id, SHORT_IDS)};
         rx_keep_fmt = cio_pkg::KEEP_ALL;
      end else begin
         rx_user_fmt[cio_pkg::CRF_BIT] = rx_crf;
         rx_keep_fmt = cio_pkg::raw_keep(rx_last, rx_keep);
      end
      if (!rx_first_r) begin
         rx_user_fmt = cio_pkg::USER_RST;
      end
   end

   assign rx_in_beat = {
      rx_data,
      rx_keep_fmt,
      rx_last,
      rx_user_fmt,
      rx_first_r
   };

   // beat held until taken
   // Ready is gated by ce inside the stage, as on transmit
   cio_stage #(.W(BW)) u_rx (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .ce        (ce),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_beat   (rx_in_beat),
      .out_valid (rx_out_valid),
      .out_ready (port.iorx_tready),
      .out_beat  (rx_out_beat)
   );

   // Receive outputs straight from the stage flops
   assign port.iorx_tvalid = rx_out_valid;
   assign port.iorx_tdata  = rx_out_beat[DATA_MSB -: 64];
   assign port.iorx_tkeep  = rx_out_beat[KEEP_MSB -: 8];
   assign port.iorx_tlast  = rx_out_beat[LAST_POS];
   assign port.iorx_tuser  = rx_out_beat[USER_MSB:USER_LSB];
endmodule : cio_endpoint

// ===== design/cio_pkg.sv
// Shared constants and types for the condensed I/O stream port
package cio_pkg;
   localparam int DATA_W      = 64;
   localparam int KEEP_W      = 8;
   localparam int USER_W      = 32;
   localparam int RAW_USER_W  = 8;
   localparam int ID_W        = 16;
   localparam int SRC_ID_LSB  = 16;
   localparam int DST_ID_LSB  = 0;
   localparam int CRF_BIT     = 1;
   localparam int SHORT_ID_W  = 8;
   localparam logic [7:0]  KEEP_ALL   = 8'hff;
   localparam logic [31:0] USER_RST   = 32'h0000_0000;
   localparam logic [63:0] DATA_RST   = 64'h0;
   localparam logic [7:0]  KEEP_RST   = 8'h00;

   // Packet format fixed at generation, shared by both channels
   typedef enum logic [0:0] {
      FMT_COMPACT = 1'b0,
      FMT_RAW     = 1'b1
   } fmt_e;

   // Force upper byte of a 16-bit id to zero when 8-bit ids are in use
   function automatic logic [15:0] narrow_id(input logic [15:0] id, input logic short_ids);
      narrow_id = short_ids ? {8'h00, id[7:0]} : id;
   endfunction : narrow_id

   // Keep value for a beat in the raw stream format
   function automatic logic [7:0] raw_keep(input logic last, input logic [7:0] keep);
      raw_keep = last ? keep : KEEP_ALL;
   endfunction : raw_keep
endpackage : cio_pkg

// ===== design/cio_if.sv
// Interface joining the endpoint and the user design
`timescale 1ns/1ps
interface cio_if;
   // Transmit channel: user design is source
   logic        iotx_tvalid;
   logic        iotx_tready;
   logic [63:0] iotx_tdata;
   logic [7:0]  iotx_tkeep;
   logic        iotx_tlast;
   logic [31:0] iotx_tuser;
   // Receive channel: endpoint is source
   logic        iorx_tvalid;
   logic        iorx_tready;
   logic [63:0] iorx_tdata;
   logic [7:0]  iorx_tkeep;
   logic        iorx_tlast;
   logic [31:0] iorx_tuser;

   modport endpoint (
      input  iotx_tvalid, iotx_tdata, iotx_tkeep, iotx_tlast, iotx_tuser, iorx_tready,
      output iotx_tready, iorx_tvalid, iorx_tdata, iorx_tkeep, iorx_tlast, iorx_tuser
   );
   modport user (
      output iotx_tvalid, iotx_tdata, iotx_tkeep, iotx_tlast, iotx_tuser, iorx_tready,
      input  iotx_tready, iorx_tvalid, iorx_tdata, iorx_tkeep, iorx_tlast, iorx_tuser
   );
endinterface : cio_if

// ===== design/cio_stage.sv
// One-deep skid-free register stage for a stream beat, with clock-enable gating
`timescale 1ns/1ps
module cio_stage #(
   parameter int W = 106
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_beat,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_beat
);
   logic         valid_r;
   logic         valid_nxt;
   logic [W-1:0] beat_r;
   logic [W-1:0] beat_nxt;

   // Accept when empty or when the held beat leaves this cycle; a low
   // clock-enable withholds ready so no beat is handed over and then lost
   assign in_ready  = ce & (~valid_r | out_ready);
   assign out_valid = valid_r;
   assign out_beat  = beat_r;

   // Next state: a held beat never changes until taken
   always_comb begin
      valid_nxt = valid_r;
      beat_nxt  = beat_r;
      if (in_ready) begin
         valid_nxt = in_valid;
         if (in_valid) begin
            beat_nxt = in_beat;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         valid_r <= 1'b0;
         beat_r  <= '0;
      end else if (ce) begin
         valid_r <= valid_nxt;
         beat_r  <= beat_nxt;
      end
   end
endmodule : cio_stage

// ===== design/cio_user.sv
// User-design end of the condensed I/O stream port
`timescale 1ns/1ps
module cio_user #(
   parameter cio_pkg::fmt_e FMT       = cio_pkg::FMT_COMPACT,
   parameter bit            SHORT_IDS = 1'b0
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         ce,
   cio_if.user               port,
   input  wire logic [15:0]  device_id,
   // Outbound request from user logic
   input  wire logic         req_valid,
   output logic              req_ready,
   input  wire logic [63:0]  req_data,
   input  wire logic [7:0]   req_keep,
   input  wire logic         req_last,
   input  wire logic [15:0]  req_dst_id,
   input  wire logic         req_crf,
   // Inbound beat to user logic
   output logic              ind_valid,
   input  wire logic         ind_ready,
   output logic [63:0]       ind_data,
   output logic [7:0]        ind_keep,
   output logic              ind_last,
   output logic              ind_first,
   output logic [31:0]       ind_user
);
   localparam int BW = 64 + 8 + 1 + 32 + 1;

   logic          first_r;
   logic          first_nxt;
   logic [31:0]   user_fmt;
   logic [7:0]    keep_fmt;
   logic [BW-1:0] tx_beat;
   logic [BW-1:0] rx_beat;
   logic [BW-1:0] ind_beat;

   // Build user field and keep per format; reserved bits stay zero
   always_comb begin
      user_fmt = cio_pkg::USER_RST;
      keep_fmt = cio_pkg::KEEP_ALL;
      if (FMT == cio_pkg::FMT_COMPACT) begin
         user_fmt = {cio_pkg::narrow_id(device_id, SHORT_IDS), cio_pkg::narrow_id(req_dst_id, SHORT_IDS)};
         keep_fmt = cio_pkg::KEEP_ALL;
      end else begin
         user_fmt[cio_pkg::CRF_BIT] = req_crf;
         keep_fmt = cio_pkg::raw_keep(req_last, req_keep);
      end
      if (!first_r) begin
         user_fmt = cio_pkg::USER_RST;
      end
   end

   // Start-of-packet tracking on the outbound side
   always_comb begin
      first_nxt = first_r;
      if (req_valid && req_ready) begin
         first_nxt = req_last;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         first_r <= 1'b1;
      end else if (ce) begin
         first_r <= first_nxt;
      end
   end

   assign tx_beat = {req_data, keep_fmt, req_last, user_fmt, first_r};

   cio_stage #(.W(BW)) u_tx (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .ce        (ce),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_beat   (tx_beat),
      .out_valid (port.iotx_tvalid),
      .out_ready (port.iotx_tready),
      .out_beat  (rx_beat)
   );
   assign port.iotx_tdata = rx_beat[BW-1 -: 64];
   assign port.iotx_tkeep = rx_beat[BW-65 -: 8];
   assign port.iotx_tlast = rx_beat[BW-73];
   assign port.iotx_tuser = rx_beat[32:1];

   // Inbound stage registers the receive channel so outputs come from flops
   cio_stage #(.W(BW)) u_rx (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .ce        (ce),
      .in_valid  (port.iorx_tvalid),
      .in_ready  (port.iorx_tready),
      .in_beat   ({port.iorx_tdata, port.iorx_tkeep, port.iorx_tlast, port.iorx_tuser, 1'b0}),
      .out_valid (ind_valid),
      .out_ready (ind_ready),
      .out_beat  (ind_beat)
   );
   assign ind_data  = ind_beat[BW-1 -: 64];
   assign ind_keep  = ind_beat[BW-65 -: 8];
   assign ind_last  = ind_beat[BW-73];
   assign ind_user  = ind_beat[32:1];
   assign ind_first = 1'b0;
endmodule : cio_user

// ===== testbench/cio_port_assertions.sv
// Concurrent checks on the wires joining the two ends of the port
`timescale 1ns/1ps
module cio_port_assertions (
   input wire logic        core_clk,
   input wire logic        nrst,
   input wire logic        iotx_tvalid,
   input wire logic        iotx_tready,
   input wire logic [63:0] iotx_tdata,
   input wire logic [7:0]  iotx_tkeep,
   input wire logic        iotx_tlast,
   input wire logic [31:0] iotx_tuser,
   input wire logic        iorx_tvalid,
   input wire logic        iorx_tready,
   input wire logic [63:0] iorx_tdata,
   input wire logic [7:0]  iorx_tkeep,
   input wire logic        iorx_tlast,
   input wire logic [31:0] iorx_tuser
);
   logic tx_first_r;
   logic tx_first_nxt;
   logic rx_first_r;
   logic rx_first_nxt;

   // First-beat trackers; the beat after an accepted last beat opens a packet
   always_comb begin
      tx_first_nxt = tx_first_r;
      rx_first_nxt = rx_first_r;
      if (iotx_tvalid && iotx_tready) tx_first_nxt = iotx_tlast;
      if (iorx_tvalid && iorx_tready) rx_first_nxt = iorx_tlast;
   end

   // Registers only; reset starts both channels at a packet boundary
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_first_r <= 1'b1;
         rx_first_r <= 1'b1;
      end else begin
         tx_first_r <= tx_first_nxt;
         rx_first_r <= rx_first_nxt;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_tx_hold_beat: assert property (iotx_tvalid && !iotx_tready |=> iotx_tvalid && $stable({iotx_tdata, iotx_tkeep}))
      else $error("transmit beat changed while waiting");
   a_tx_hold_frame: assert property (iotx_tvalid && !iotx_tready |=> $stable({iotx_tlast, iotx_tuser}))
      else $error("transmit framing changed while waiting");
   a_rx_hold_beat: assert property (iorx_tvalid && !iorx_tready |=> iorx_tvalid && $stable({iorx_tdata, iorx_tkeep}))
      else $error("receive beat changed while waiting");
   a_rx_hold_frame: assert property (iorx_tvalid && !iorx_tready |=> $stable({iorx_tlast, iorx_tuser}))
      else $error("receive framing changed while waiting");
   a_tx_keep_ones: assert property (iotx_tvalid |-> iotx_tkeep == 8'hff)
      else $error("transmit keep not all ones");
   a_rx_keep_ones: assert property (iorx_tvalid |-> iorx_tkeep == 8'hff)
      else $error("receive keep not all ones");
   a_tx_user_later: assert property (iotx_tvalid && !tx_first_r |-> iotx_tuser == 32'h0)
      else $error("transmit user field set on later beat");
   a_rx_user_later: assert property (iorx_tvalid && !rx_first_r |-> iorx_tuser == 32'h0)
      else $error("receive user field set on later beat");
endmodule : cio_port_assertions

// ===== testbench/condensed_io_stream_port_tb.sv
// Testbench joining both ends of the port in the compact header format
`timescale 1ns/1ps
module condensed_io_stream_port_tb;
   logic          core_clk, nrst, ce, tx_valid, tx_ready, tx_last, tx_first, rx_valid, rx_ready, rx_last;
   logic          req_valid, req_ready, req_last, req_crf, ind_valid, ind_ready, ind_last, ind_first, rx_crf;
   logic [63:0]   tx_data, rx_data, req_data, ind_data;
   logic [7:0]    tx_keep, rx_keep, req_keep, ind_keep;
   logic [31:0]   tx_user, ind_user;
   logic [15:0]   device_id, req_dst_id, rx_src_id, rx_dst_id;
   logic [105:0]  txq[$];
   logic [104:0]  rxq[$];
   int            bad_count, checks;

   cio_if cio_if_i ();
   cio_endpoint cio_endpoint_i (.core_clk(core_clk), .nrst(nrst), .ce(ce), .port(cio_if_i), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .tx_keep(tx_keep), .tx_last(tx_last), .tx_user(tx_user),
      .tx_first(tx_first), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_keep(rx_keep),
      .rx_last(rx_last), .rx_src_id(rx_src_id), .rx_dst_id(rx_dst_id), .rx_crf(rx_crf));
   cio_user cio_user_i (.core_clk(core_clk), .nrst(nrst), .ce(ce), .port(cio_if_i), .device_id(device_id),
      .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data), .req_keep(req_keep), .req_last(req_last),
      .req_dst_id(req_dst_id), .req_crf(req_crf), .ind_valid(ind_valid), .ind_ready(ind_ready),
      .ind_data(ind_data), .ind_keep(ind_keep), .ind_last(ind_last), .ind_first(ind_first), .ind_user(ind_user));
   cio_port_assertions cio_port_assertions_i (.core_clk(core_clk), .nrst(nrst),
      .iotx_tvalid(cio_if_i.iotx_tvalid), .iotx_tready(cio_if_i.iotx_tready), .iotx_tdata(cio_if_i.iotx_tdata),
      .iotx_tkeep(cio_if_i.iotx_tkeep), .iotx_tlast(cio_if_i.iotx_tlast), .iotx_tuser(cio_if_i.iotx_tuser),
      .iorx_tvalid(cio_if_i.iorx_tvalid), .iorx_tready(cio_if_i.iorx_tready), .iorx_tdata(cio_if_i.iorx_tdata),
      .iorx_tkeep(cio_if_i.iorx_tkeep), .iorx_tlast(cio_if_i.iorx_tlast), .iorx_tuser(cio_if_i.iorx_tuser));

   // 25 MHz clock
   always #20 core_clk = ~core_clk;

   // Collect beats taken at the endpoint transport output and at the user inbound output
   always @(posedge core_clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back({tx_first, tx_last, tx_user, tx_keep, tx_data});
      if (ind_valid === 1'b1 && ind_ready === 1'b1) rxq.push_back({ind_last, ind_user, ind_keep, ind_data});
   end

   task stop_test;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test

   task check(input string what, input logic [127:0] seen, input logic [127:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Offer one beat and hold it until ready is seen at a falling edge, then through the next rising edge
   task push(input bit rxs, input logic [63:0] d, input logic l, input logic [7:0] k);
      int n;
      if (rxs) begin
         rx_valid <= 1'b1; rx_data <= d; rx_last <= l; rx_keep <= k;
      end else begin
         req_valid <= 1'b1; req_data <= d; req_last <= l; req_keep <= k;
      end
      for (n = 0; n < 20; n++) begin
         @(negedge core_clk);
         if ((rxs ? rx_ready : req_ready) === 1'b1) break;
         @(posedge core_clk);
      end
      if (n == 20) begin
         bad_count++;
         stop_test();
      end
      @(posedge core_clk);
   endtask : push

   // Two packets out while the far side stalls, so both stages fill
   task t_tx;
      int i;
      logic f;
      tx_ready <= 1'b0;
      fork
         for (i = 0; i < 4; i++) push(1'b0, 64'ha5a5_0000_0000_0000 | 64'(i), i >= 2, 8'hff);
         begin repeat (6) @(posedge core_clk); tx_ready <= 1'b1; end
      join
      req_valid <= 1'b0;
      repeat (6) @(posedge core_clk);
      check("tx beat count", 128'(txq.size()), 128'd4);
      for (i = 0; i < 4; i++) begin
         f = (i == 0 || i == 3);
         check("tx data", 128'(txq[i][63:0]), 128'(64'ha5a5_0000_0000_0000 | 64'(i)));
         check("tx keep", 128'(txq[i][71:64]), 128'(8'hff));
         check("tx user", 128'(txq[i][103:72]), 128'(f ? {device_id, req_dst_id} : 32'h0));
         check("tx last", 128'(txq[i][104]), 128'(i >= 2));
         check("tx first", 128'(txq[i][105]), 128'(f));
      end
      $display("test tx done");
   endtask : t_tx

   // Inbound packets with a short final keep and a stalled consumer
   task t_rx;
      int i;
      ind_ready <= 1'b0;
      fork
         for (i = 0; i < 3; i++) push(1'b1, 64'h5a00_0000_0000_0000 | 64'(i), i >= 1, i >= 1 ? 8'h0f : 8'hff);
         begin repeat (6) @(posedge core_clk); ind_ready <= 1'b1; end
      join
      rx_valid <= 1'b0;
      repeat (6) @(posedge core_clk);
      check("rx beat count", 128'(rxq.size()), 128'd3);
      for (i = 0; i < 3; i++) begin
         check("rx data", 128'(rxq[i][63:0]), 128'(64'h5a00_0000_0000_0000 | 64'(i)));
         check("rx keep", 128'(rxq[i][71:64]), 128'(8'hff));
         check("rx last", 128'(rxq[i][104]), 128'(i >= 1));
         if (i != 1) check("rx user", 128'(rxq[i][103:72]), 128'({rx_src_id, rx_dst_id}));
      end
      $display("test rx done");
   endtask : t_rx

   // Bound on the whole run
   initial begin
      #400000;
      bad_count++;
      stop_test();
   end

   initial begin
      core_clk = 1'b0; nrst = 1'b0; ce = 1'b1; tx_ready = 1'b1; ind_ready = 1'b1;
      rx_valid = 1'b0; rx_data = 64'h0; rx_keep = 8'hff; rx_last = 1'b0; rx_crf = 1'b0;
      req_valid = 1'b0; req_data = 64'h0; req_keep = 8'hff; req_last = 1'b0; req_crf = 1'b0;
      device_id = 16'h0017; req_dst_id = 16'h0042; rx_src_id = 16'h0031; rx_dst_id = 16'h0017;
      bad_count = 0; checks = 0;
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_tx();
      t_rx();
      stop_test();
   end
endmodule : condensed_io_stream_port_tb
